// >>> design/bit_rotate_pkg.sv
// Constants, field layout and carrier types of the rotate unit.
// Assumes one core clock; the decoder and register file share it.
package bit_rotate_pkg;

   localparam int DATA_W = 32;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int OPC_W = 16;
   localparam int CNT_W = 6;
   localparam int IDX_W = 3;
   localparam int ADDR_W = 4;

   // Opcode field positions.
   localparam int OPC_GRP_HI = 15;
   localparam int OPC_GRP_LO = 12;
   localparam int OPC_CNT_HI = 11;
   localparam int OPC_CNT_LO = 9;
   localparam int OPC_DIR = 8;
   localparam int OPC_SIZE_HI = 7;
   localparam int OPC_SIZE_LO = 6;
   localparam int OPC_IR = 5;
   localparam int OPC_TYPE_HI = 4;
   localparam int OPC_TYPE_LO = 3;
   localparam int OPC_MODE_HI = 5;
   localparam int OPC_MODE_LO = 3;
   localparam int OPC_REG_HI = 2;
   localparam int OPC_REG_LO = 0;

   // Opcode field values.
   localparam logic [3:0] GRP_SHIFT = 4'he;
   localparam logic [1:0] REG_TYPE_ROT = 2'h3;
   localparam logic [2:0] MEM_TYPE_ROT = 3'h3;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;
   localparam logic [1:0] SIZE_MEM = 2'h3;
   localparam logic DIR_RIGHT = 1'b0;
   localparam logic DIR_LEFT = 1'b1;
   localparam logic IR_IMM = 1'b0;
   localparam logic IR_REG = 1'b1;
   localparam logic [2:0] IMM_ZERO = 3'h0;
   localparam logic [CNT_W-1:0] IMM_ZERO_CNT = 6'h08;
   localparam logic [CNT_W-1:0] MEM_CNT = 6'h01;

   // Effective address modes and registers of the memory form.
   localparam logic [2:0] EA_IND = 3'h2;
   localparam logic [2:0] EA_POSTINC = 3'h3;
   localparam logic [2:0] EA_PREDEC = 3'h4;
   localparam logic [2:0] EA_DISP = 3'h5;
   localparam logic [2:0] EA_INDEX = 3'h6;
   localparam logic [2:0] EA_EXT = 3'h7;
   localparam logic [2:0] EA_ABS_W = 3'h0;
   localparam logic [2:0] EA_ABS_L = 3'h1;

   // Register port map.
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_OPCNT = 4'h8;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam int ST_C_BIT = 0;
   localparam int ST_V_BIT = 1;
   localparam int ST_Z_BIT = 2;
   localparam int ST_N_BIT = 3;
   localparam int ST_ILL_BIT = 4;
   localparam int ST_BUSY_BIT = 5;

   typedef struct packed {
      logic n;
      logic z;
      logic v;
      logic c;
   } flags_s;

   typedef struct packed {
      logic valid;
      logic [OPC_W-1:0] opcode;
      logic [DATA_W-1:0] dreg;
      logic [DATA_W-1:0] creg;
      logic [WORD_W-1:0] mem;
   } rot_req_s;

   typedef struct packed {
      logic valid;
      logic illegal;
      logic reg_we;
      logic mem_we;
      logic flags_we;
      logic [IDX_W-1:0] reg_idx;
      logic [DATA_W-1:0] data;
      flags_s flags;
   } rot_rsp_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } fsm_e;

   typedef struct packed {
      fsm_e fsm;
      rot_req_s req;
      rot_rsp_s rsp;
      logic en;
      flags_s last_flags;
      logic last_ill;
      logic [DATA_W-1:0] opcnt;
      logic [DATA_W-1:0] rdata;
   } state_s;

endpackage

// >>> design/bit_rotate_unit.sv
// Rotate-without-extend datapath with its opcode decode and a small register port.
// Assumes the decoder hands in the opcode with the destination register, the count
// register and the memory word already fetched, all on the core clock.
//
// Overview of operation
// - An immediate count field of zero means eight positions, one to seven mean themselves.
// - A register count is the named data register taken modulo 64.
// - Direction bit zero rotates right and one rotates left, for register and memory forms.
// - Size code 00 is byte, 01 is word and 10 is long for register rotates.
// - Count-source bit zero picks the immediate count and one picks the register count.
// - A left rotate sends each bit leaving the top into carry and back in at the bottom.
// - A right rotate sends each bit leaving the bottom into carry and back in at the top.
// - The extend flag is neither read nor changed by any form of this rotate.
// - Negative follows the result's top bit at the selected width.
// - Zero is set only for an all-zero result at that width and overflow is always cleared.
// - Carry takes the last bit rotated out and is cleared for an effective count of zero.
// - The memory form rotates a word operand by exactly one position.
// - The memory form accepts only memory alterable addressing modes.
// - The register form writes the result back into the same register at the selected width.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bit_rotate_unit (
   input wire logic clk,
   input wire logic arst_n,
   input wire bit_rotate_pkg::rot_req_s req,
   output logic req_ready,
   output bit_rotate_pkg::rot_rsp_s rsp,
   input wire bit_rotate_pkg::bus_req_s bus,
   output logic [bit_rotate_pkg::DATA_W-1:0] bus_rdata
);
   import bit_rotate_pkg::*;

   localparam state_s STATE_RESET = '{
      fsm: ST_IDLE,
      req: '0,
      rsp: '0,
      en: CTRL_EN_RESET,
      last_flags: '0,
      last_ill: 1'b0,
      opcnt: '0,
      rdata: '0
   };

   state_s st_reg;
   state_s st_next;

   logic [OPC_W-1:0] opc;
   logic [1:0] size;
   logic is_grp;
   logic is_mem;
   logic is_reg;
   logic ea_ok;
   logic left;
   logic [CNT_W-1:0] imm_cnt;
   logic [CNT_W-1:0] reg_cnt;
   logic [CNT_W-1:0] amount;
   logic [WORD_W-1:0] word_in;
   logic [BYTE_W-1:0] r8;
   logic [WORD_W-1:0] r16;
   logic [DATA_W-1:0] r32;
   logic c8;
   logic c16;
   logic c32;
   logic [DATA_W-1:0] wb_data;
   flags_s fl;
   logic legal;

   // Decode works on the latched request, so the inputs may change after acceptance.
   assign opc = st_reg.req.opcode;
   assign size = opc[OPC_SIZE_HI:OPC_SIZE_LO];
   assign is_grp = opc[OPC_GRP_HI:OPC_GRP_LO] == GRP_SHIFT;
   assign is_mem = is_grp && (opc[OPC_CNT_HI:OPC_CNT_LO] == MEM_TYPE_ROT)
                   && (size == SIZE_MEM);
   assign is_reg = is_grp && (opc[OPC_TYPE_HI:OPC_TYPE_LO] == REG_TYPE_ROT)
                   && (size != SIZE_MEM);
   assign left = opc[OPC_DIR] == DIR_LEFT;

   always_comb begin
      case (opc[OPC_MODE_HI:OPC_MODE_LO])
         EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP, EA_INDEX: begin
            ea_ok = 1'b1;
         end
         EA_EXT: begin
            ea_ok = (opc[OPC_REG_HI:OPC_REG_LO] == EA_ABS_W)
                    || (opc[OPC_REG_HI:OPC_REG_LO] == EA_ABS_L);
         end
         default: begin
            ea_ok = 1'b0;
         end
      endcase
   end

   assign legal = is_reg || (is_mem && ea_ok);

   always_comb begin
      if (opc[OPC_CNT_HI:OPC_CNT_LO] == IMM_ZERO) begin
         imm_cnt = IMM_ZERO_CNT;
      end else begin
         imm_cnt = {3'h0, opc[OPC_CNT_HI:OPC_CNT_LO]};
      end
   end

   // Only the low six bits matter, which is the reduction modulo 64.
   assign reg_cnt = st_reg.req.creg[CNT_W-1:0];

   always_comb begin
      if (is_mem) begin
         amount = MEM_CNT;
      end else if (opc[OPC_IR] == IR_REG) begin
         amount = reg_cnt;
      end else begin
         amount = imm_cnt;
      end
   end

   assign word_in = is_mem ? st_reg.req.mem : st_reg.req.dreg[WORD_W-1:0];

   // One slice per width keeps each rotate a short shift; the cost is three small rotators.
   rot_slice #(
      .W(BYTE_W)
   ) u_rot8 (
      .operand(st_reg.req.dreg[BYTE_W-1:0]),
      .amount(amount),
      .left(left),
      .result(r8),
      .carry(c8)
   );

   rot_slice #(
      .W(WORD_W)
   ) u_rot16 (
      .operand(word_in),
      .amount(amount),
      .left(left),
      .result(r16),
      .carry(c16)
   );

   rot_slice #(
      .W(DATA_W)
   ) u_rot32 (
      .operand(st_reg.req.dreg),
      .amount(amount),
      .left(left),
      .result(r32),
      .carry(c32)
   );

   // Width select; upper bits of the register outside the width are kept.
   always_comb begin
      wb_data = st_reg.req.dreg;
      fl = '0;
      if (is_mem) begin
         wb_data = {{(DATA_W-WORD_W){1'b0}}, r16};
         fl.n = r16[WORD_W-1];
         fl.z = r16 == '0;
         fl.c = c16;
      end else begin
         case (size)
            SIZE_BYTE: begin
               wb_data = {st_reg.req.dreg[DATA_W-1:BYTE_W], r8};
               fl.n = r8[BYTE_W-1];
               fl.z = r8 == '0;
               fl.c = c8;
            end
            SIZE_WORD: begin
               wb_data = {st_reg.req.dreg[DATA_W-1:WORD_W], r16};
               fl.n = r16[WORD_W-1];
               fl.z = r16 == '0;
               fl.c = c16;
            end
            SIZE_LONG: begin
               wb_data = r32;
               fl.n = r32[DATA_W-1];
               fl.z = r32 == '0;
               fl.c = c32;
            end
            default: begin
               wb_data = st_reg.req.dreg;
            end
         endcase
      end
      // A zero count rotates by nothing, so the operand comes back as it went in.
      if (amount == '0) begin
         wb_data = st_reg.req.dreg;
      end
      fl.v = 1'b0;
   end

   always_comb begin
      st_next = st_reg;
      st_next.rsp.valid = 1'b0;
      st_next.rdata = '0;

      case (st_reg.fsm)
         ST_IDLE: begin
            if (req.valid && st_reg.en) begin
               st_next.req = req;
               st_next.fsm = ST_EXEC;
            end
         end
         ST_EXEC: begin
            st_next.rsp.valid = 1'b1;
            st_next.rsp.illegal = !legal;
            st_next.rsp.reg_we = is_reg;
            st_next.rsp.mem_we = is_mem && ea_ok;
            // The flag port carries no extend bit, so the core keeps its own value.
            st_next.rsp.flags_we = legal;
            st_next.rsp.reg_idx = opc[OPC_REG_HI:OPC_REG_LO];
            st_next.rsp.data = legal ? wb_data : '0;
            st_next.rsp.flags = legal ? fl : '0;
            st_next.last_ill = !legal;
            if (legal) begin
               st_next.last_flags = fl;
               st_next.opcnt = st_reg.opcnt + 32'h1;
            end
            st_next.fsm = ST_DONE;
         end
         ST_DONE: begin
            st_next.fsm = ST_IDLE;
         end
         default: begin
            st_next.fsm = ST_IDLE;
         end
      endcase

      // Register port; a write to the counter clears it and loses a count
      // completed in the same cycle, which software should avoid.
      if (bus.wr) begin
         case (bus.addr)
            OFS_CTRL: begin
               st_next.en = bus.wdata[CTRL_EN_BIT];
            end
            OFS_OPCNT: begin
               st_next.opcnt = '0;
            end
            default: begin
               st_next.en = st_reg.en;
            end
         endcase
      end
      if (bus.rd) begin
         case (bus.addr)
            OFS_CTRL: begin
               st_next.rdata[CTRL_EN_BIT] = st_reg.en;
            end
            OFS_STATUS: begin
               st_next.rdata[ST_C_BIT] = st_reg.last_flags.c;
               st_next.rdata[ST_V_BIT] = st_reg.last_flags.v;
               st_next.rdata[ST_Z_BIT] = st_reg.last_flags.z;
               st_next.rdata[ST_N_BIT] = st_reg.last_flags.n;
               st_next.rdata[ST_ILL_BIT] = st_reg.last_ill;
               st_next.rdata[ST_BUSY_BIT] = st_reg.fsm != ST_IDLE;
            end
            OFS_OPCNT: begin
               st_next.rdata = st_reg.opcnt;
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= STATE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign req_ready = (st_reg.fsm == ST_IDLE) && st_reg.en;
   assign rsp = st_reg.rsp;
   assign bus_rdata = st_reg.rdata;
endmodule
`default_nettype wire

// >>> design/rot_slice.sv
// Rotator of one operand width, without any extend bit in the loop.
// Assumes W is a power of two; the amount is already reduced modulo 64.
`timescale 1ns/1ps
`default_nettype none
module rot_slice #(
   parameter int W = 8
) (
   input wire logic [W-1:0] operand,
   input wire logic [5:0] amount,
   input wire logic left,
   output logic [W-1:0] result,
   output logic carry
);
   localparam int SW = $clog2(W);

   logic [SW-1:0] sh;
   logic [2*W-1:0] dbl;
   logic [2*W-1:0] lsh;
   logic [2*W-1:0] rsh;

   // A doubled copy turns a rotate into a plain shift of one window.
   assign sh = amount[SW-1:0];
   assign dbl = {operand, operand};
   assign lsh = dbl << sh;
   assign rsh = dbl >> sh;

   always_comb begin
      if (left) begin
         result = lsh[2*W-1:W];
         carry = result[0];
      end else begin
         result = rsh[W-1:0];
         carry = result[W-1];
      end
      if (amount == 6'h00) begin
         carry = 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> tb/bit_rotate_properties.sv
// Checker of the rotate unit, watching only the ports of its top module.
// Assumes an answer two edges after a request is taken.
`timescale 1ns/1ps
`default_nettype none
module bit_rotate_properties (
   input wire logic clk,
   input wire logic arst_n,
   input wire bit_rotate_pkg::rot_req_s req,
   input wire logic req_ready,
   input wire bit_rotate_pkg::rot_rsp_s rsp,
   input wire bit_rotate_pkg::bus_req_s bus,
   input wire logic [bit_rotate_pkg::DATA_W-1:0] bus_rdata
);
   import bit_rotate_pkg::*;
   rot_req_s taken_reg;
   logic reg_form, mem_form, mode_ok;
   logic [31:0] m;
   logic [4:0] top;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // The taken request is kept so each answer can be judged against its own operands.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) taken_reg <= '0;
      else if (req.valid && req_ready) taken_reg <= req;
   end
   always_comb begin
      reg_form = taken_reg.opcode[15:12] == GRP_SHIFT && taken_reg.opcode[4:3] == REG_TYPE_ROT
         && taken_reg.opcode[7:6] != SIZE_MEM;
      mem_form = taken_reg.opcode[15:9] == {GRP_SHIFT, MEM_TYPE_ROT}
         && taken_reg.opcode[7:6] == SIZE_MEM;
      mode_ok = taken_reg.opcode[5:3] inside {[EA_IND:EA_INDEX]}
         || (taken_reg.opcode[5:3] == EA_EXT && taken_reg.opcode[2:1] == 2'h0);
      m = taken_reg.opcode[7:6] == SIZE_BYTE ? 32'hff :
         taken_reg.opcode[7:6] == SIZE_WORD ? 32'hffff : 32'hffffffff;
      top = taken_reg.opcode[7:6] == SIZE_BYTE ? 5'h7 :
         taken_reg.opcode[7:6] == SIZE_WORD ? 5'hf : 5'h1f;
   end
   sequence s_take;
      req.valid && req_ready;
   endsequence
   sequence s_busy;
      !req_ready [*2];
   endsequence
   sequence s_answer;
      !rsp.valid ##1 rsp.valid;
   endsequence
   a_answer_delay: assert property (s_take |=> s_busy and s_answer)
      else $error("answer not two cycles after request");
   a_ovf_cleared: assert property (rsp.valid && rsp.flags_we |-> !rsp.flags.v)
      else $error("overflow flag set");
   a_neg_top: assert property (rsp.valid && reg_form |-> rsp.flags.n == rsp.data[top])
      else $error("negative flag wrong");
   a_zero_width: assert property (rsp.valid && reg_form |-> rsp.flags.z == ((rsp.data & m) == 0))
      else $error("zero flag wrong");
   a_upper_kept: assert property (rsp.valid && reg_form |-> rsp.reg_we
      && ((rsp.data ^ taken_reg.dreg) & ~m) == 0 && rsp.reg_idx == taken_reg.opcode[2:0])
      else $error("write back wrong");
   a_imm_eight: assert property (rsp.valid && reg_form
      && taken_reg.opcode[11:9] == 3'h0 && taken_reg.opcode[7:5] == 3'h0
      |-> rsp.data == taken_reg.dreg
      && rsp.flags.c == (taken_reg.opcode[8] ? taken_reg.dreg[0] : taken_reg.dreg[7]))
      else $error("eight position byte rotate wrong");
   a_zero_count: assert property (rsp.valid && reg_form && taken_reg.opcode[5]
      && taken_reg.creg[5:0] == 6'h0 |-> rsp.data == taken_reg.dreg && !rsp.flags.c)
      else $error("zero count changed operand or carry");
   a_mem_step: assert property (rsp.valid && mem_form && mode_ok |-> rsp.mem_we
      && rsp.data[15:0] == (taken_reg.opcode[8] ? {taken_reg.mem[14:0], taken_reg.mem[15]}
      : {taken_reg.mem[0], taken_reg.mem[15:1]}))
      else $error("memory rotate wrong");
   a_mem_mode: assert property (rsp.valid && mem_form && !mode_ok |-> rsp.illegal && !rsp.mem_we)
      else $error("bad address mode accepted");
   a_rdata_idle: assert property (!bus.rd |=> bus_rdata == 0)
      else $error("read data outside read answer");
endmodule
bind bit_rotate_unit bit_rotate_properties bit_rotate_properties_i (.clk(clk), .arst_n(arst_n),
   .req(req), .req_ready(req_ready), .rsp(rsp), .bus(bus), .bus_rdata(bus_rdata));
`default_nettype wire

// >>> tb/bit_rotate_unit_tb.sv
// Self-checking bench of the rotate unit with random and corner opcodes.
// Assumes the core side model supplies operands and takes write backs.
`timescale 1ns/1ps
`default_nettype none
module bit_rotate_unit_tb;
   import bit_rotate_pkg::*;
   logic clk, arst_n, go, req_ready;
   logic [15:0] opcode;
   logic [31:0] bus_rdata;
   logic [3:0] last_f;
   rot_req_s req;
   rot_rsp_s rsp;
   bus_req_s bus;
   int seed, errors, check_count;
   bit_rotate_unit bit_rotate_unit_i (.clk(clk), .arst_n(arst_n), .req(req),
      .req_ready(req_ready), .rsp(rsp), .bus(bus), .bus_rdata(bus_rdata));
   core_side_model core_side_model_i (.clk(clk), .arst_n(arst_n), .go(go), .opcode(opcode),
      .req_ready(req_ready), .rsp(rsp), .req(req));
   always #20 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d, checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Rotates the low w bits of v by n places and returns the last bit out above them.
   function automatic logic [32:0] rot(logic [31:0] v, int w, int n, logic l);
      logic c;
      logic [31:0] m;
      c = 1'b0;
      m = 32'hffffffff >> (32 - w);
      for (int i = 0; i < n; i++) begin
         c = l ? v[w-1] : v[0];
         v = l ? ((v << 1) | 32'(c)) & m : (v >> 1) | (32'(c) << (w - 1));
      end
      return {c, v};
   endfunction
   task automatic bus_op(input logic [3:0] a, input logic [31:0] d, input logic wr);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: wr, rd: !wr};
      @(posedge clk);
      bus <= '0;
      @(negedge clk);
      if (!wr) check(bus_rdata, d, "register read");
   endtask
   task automatic run(input logic [15:0] op);
      logic [31:0] d, mk, e;
      logic [32:0] r;
      logic mf, il;
      int w, n, i;
      mf = op[7:6] == SIZE_MEM;
      d = mf ? {16'h0, core_side_model_i.mem_word} : core_side_model_i.regs[op[2:0]];
      w = mf ? 16 : 8 << op[7:6];
      n = mf ? 1 : op[5] ? int'(core_side_model_i.regs[op[11:9]][5:0])
         : op[11:9] == 3'h0 ? 8 : int'(op[11:9]);
      mk = 32'hffffffff >> (32 - w);
      r = rot(d & mk, w, n, op[8]);
      e = (d & ~mk) | r[31:0];
      il = mf && !(op[11:9] == 3'h3 && (op[5:3] inside {[2:6]} || op[5:1] == 5'h1c));
      @(posedge clk);
      opcode <= op;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 8 && rsp.valid !== 1'b1; i++) @(negedge clk);
      if (rsp.valid !== 1'b1) begin
         errors++;
         stop_test();
      end
      check(32'(rsp.illegal), 32'(il), "illegal");
      if (!il) begin
         check(rsp.data, e, "data");
         last_f = {r[w-1], r[31:0] == 0, 1'b0, r[32]};
         check(32'(rsp.flags), 32'(last_f), "flags");
      end
      @(negedge clk);
      if (!il && !mf) check(core_side_model_i.regs[op[2:0]], e, "write back");
      if (!il && mf) check(32'(core_side_model_i.mem_word), e, "memory word");
   endtask
   initial begin
      seed = 9;
      clk = 0;
      arst_n = 0;
      go = 0;
      opcode = '0;
      bus = '0;
      errors = 0;
      check_count = 0;
      for (int k = 0; k < 8; k++) core_side_model_i.regs[k] = $random(seed);
      core_side_model_i.mem_word = 16'($random(seed));
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      bus_op(OFS_CTRL, 32'h1, 1'b0);
      bus_op(4'hc, 32'h0, 1'b0);
      run(16'he118);
      core_side_model_i.regs[1] = 32'h40;
      run(16'he2ba);
      core_side_model_i.regs[1] = 32'h20;
      run(16'he3bb);
      run(16'he0c0);
      for (int k = 0; k < 24; k++) run({7'h73, k[3], 2'h3, k[2:0], 1'b0, k[4:3]});
      bus_op(OFS_CTRL, 32'h0, 1'b1);
      @(negedge clk);
      check(32'(req_ready), 32'h0, "ready while disabled");
      bus_op(OFS_CTRL, 32'h1, 1'b1);
      bus_op(OFS_OPCNT, 32'h0, 1'b1);
      for (int k = 0; k < 40; k++) begin
         run({4'he, 3'($random(seed)), 1'($random(seed)),
            2'(($random(seed) & 32'h7fffffff) % 3), 1'($random(seed)), 2'h3, 3'($random(seed))});
      end
      bus_op(OFS_OPCNT, 32'd40, 1'b0);
      bus_op(OFS_STATUS, {28'h0, last_f}, 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire

// >>> tb/core_side_model.sv
// Decoder and data register file that feed the rotate unit.
// Assumes the bench loads register contents before issuing requests.
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic go,
   input wire logic [15:0] opcode,
   input wire logic req_ready,
   input wire bit_rotate_pkg::rot_rsp_s rsp,
   output bit_rotate_pkg::rot_req_s req
);
   import bit_rotate_pkg::*;
   logic [31:0] regs [8];
   logic [15:0] mem_word;
   // Operands are held until taken, then scrambled so stale values are never reused.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         req <= '0;
      end else if (req.valid && req_ready) begin
         req <= '{valid: 1'b0, opcode: ~req.opcode, dreg: ~req.dreg,
            creg: ~req.creg, mem: ~req.mem};
      end else if (go) begin
         req <= '{valid: 1'b1, opcode: opcode, dreg: regs[opcode[2:0]],
            creg: regs[opcode[11:9]], mem: mem_word};
      end
   end
   always @(posedge clk) begin
      if (rsp.valid && rsp.reg_we) regs[rsp.reg_idx] <= rsp.data;
      if (rsp.valid && rsp.mem_we) mem_word <= rsp.data[15:0];
   end
endmodule
`default_nettype wire
